// >>> can_engine_model.sv
// Protocol engine stand-in: error levels from counts, event pulses.
// Assumes the bench holds each event request for one cycle.
`timescale 1ns/1ps
`default_nettype none
module can_engine_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [8:0] tec_i,
  input  wire logic [8:0] rec_i,
  input  wire logic [5:0] ev_i,
  output logic      [4:0] state_o,
  output logic      [5:0] pulse_o
);
  // ------------------------------------------------------------
  // Levels: bus off, tx/rx passive, tx/rx warning
  // ------------------------------------------------------------
  // Bus-off drops tx passive so the two never stand together
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_o <= 5'h00;
      pulse_o <= 6'h00;
    end
    else
    begin
      state_o <= {tec_i >= 9'd256, tec_i inside {[9'd128:9'd255]}, rec_i >= 9'd128,
                  tec_i >= 9'd96, rec_i >= 9'd96};
      pulse_o <= ev_i;
    end
  end
endmodule
`default_nettype wire

// >>> can_fifo_ptr.sv
// Receive FIFO write and next-read pointers over the buffer area.
// Assumes one write and one read event pulse per message at most.
`timescale 1ns/1ps
`default_nettype none
module can_fifo_ptr
#(
  parameter int IW = 5
)
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [IW-1:0] start_i,
  input  wire logic [2:0]    dmabs_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [IW-1:0] wptr_o,
  output logic      [IW-1:0] rptr_o
);
  logic [IW-1:0] wptr_q;
  logic [IW-1:0] wptr_d;
  logic [IW-1:0] rptr_q;
  logic [IW-1:0] rptr_d;
  logic [5:0]    last;

  // Highest buffer index held in DMA memory
  always_comb
  begin
    unique case (dmabs_i)                                      // RULE_05
      3'h0:    last = 6'h03;
      3'h1:    last = 6'h05;
      3'h2:    last = 6'h07;
      3'h3:    last = 6'h0b;
      3'h4:    last = 6'h0f;
      3'h5:    last = 6'h17;
      default: last = 6'h1f;
    endcase
  end

  // Wrap back to the FIFO start once the last buffer is passed
  function automatic logic [IW-1:0] step(input logic [IW-1:0] p, input logic [IW-1:0] s, input logic [5:0] l);
    step = ({1'b0, p} >= l) ? s : IW'(p + 1'b1);               // RULE_06
  endfunction

  always_comb
  begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    if (wptr_q < start_i)
      wptr_d = start_i;
    else if (wr_i)
      wptr_d = step(wptr_q, start_i, last);                    // RULE_07
    if (rptr_q < start_i)
      rptr_d = start_i;
    else if (rd_i)
      rptr_d = step(rptr_q, start_i, last);                    // RULE_08
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
    end
    else
    begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  assign wptr_o = wptr_q;
  assign rptr_o = rptr_q;
endmodule
`default_nettype wire

// >>> can_irq_chk_sva.sv
// Port checker for the CAN status and interrupt block.
// Assumes it is bound onto can_irq_fifo_status.
`timescale 1ns/1ps
`default_nettype none
module can_irq_chk
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [5:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        rx_overflow_i,
  input wire logic [2:0]  dma_buffer_count_sel_o,
  input wire logic [5:0]  fifo_write_pointer_o,
  input wire logic [6:0]  interrupt_source_code_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // Bus, code, buffer count and pointer checks
  // ------------------------------------------------------------
  a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("request not answered");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_bad_addr: assert property (
    cyc_i && stb_i && !ack_o && !err_o && adr_i >= 6'h18 |=> err_o && dat_o == 32'h0)
    else $error("unmapped address not refused");
  a_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0)
    else $error("upper half not zero");
  a_code_legal: assert property (
    interrupt_source_code_o <= 7'h0f || interrupt_source_code_o inside {[7'h40:7'h44]})
    else $error("reserved code shown");
  a_dma_legal: assert property (dma_buffer_count_sel_o != 3'h7)
    else $error("reserved buffer count held");
  a_wptr_range: assert property (fifo_write_pointer_o <= 6'h1f)
    else $error("write pointer out of range");
  a_irq_code: assert property ($rose(irq_o) |=> interrupt_source_code_o != 7'h40)
    else $error("request with no code");
  a_ovf_code: assert property (rx_overflow_i |-> ##[1:2] interrupt_source_code_o inside {[7'h41:7'h43]})
    else $error("overflow not coded");
endmodule
bind can_irq_fifo_status can_irq_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .rx_overflow_i(rx_overflow_i),
  .dma_buffer_count_sel_o(dma_buffer_count_sel_o), .fifo_write_pointer_o(fifo_write_pointer_o),
  .interrupt_source_code_o(interrupt_source_code_o), .irq_o(irq_o));
`default_nettype wire

// >>> can_irq_fifo_status.sv
// Status, interrupt and FIFO configuration registers of the CAN controller.
// Assumes the protocol engine supplies level states and one-cycle event pulses.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module can_irq_fifo_status
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Engine side
  input  wire logic [4:0]  data_filter_bit_count_i,
  input  wire logic [3:0]  matched_filter_number_i,
  input  wire logic        tx_bus_off_i,
  input  wire logic        tx_error_passive_i,
  input  wire logic        rx_error_passive_i,
  input  wire logic        tx_error_warning_i,
  input  wire logic        rx_error_warning_i,
  input  wire logic        invalid_msg_i,
  input  wire logic        bus_activity_i,
  input  wire logic        fifo_almost_full_i,
  input  wire logic        rx_overflow_i,
  input  wire logic        rx_done_i,
  input  wire logic [3:0]  rx_buf_i,
  input  wire logic        tx_done_i,
  input  wire logic [3:0]  tx_buf_i,
  input  wire logic        fifo_write_i,
  input  wire logic        fifo_read_i,
  output logic      [2:0]  dma_buffer_count_sel_o,
  output logic      [4:0]  fifo_start_index_o,
  output logic      [5:0]  fifo_write_pointer_o,
  output logic      [5:0]  fifo_next_read_pointer_o,
  output logic      [6:0]  interrupt_source_code_o,
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]  flag_q;
  logic [7:0]  flag_d;
  logic [7:0]  ien_q;
  logic [7:0]  ien_d;
  logic [2:0]  dmabs_q;
  logic [2:0]  dmabs_d;
  logic [4:0]  fsa_q;
  logic [4:0]  fsa_d;
  logic [5:0]  err_state_q;
  logic [5:0]  err_state_d;
  logic [4:0]  dfilt_q;
  logic [4:0]  dfilt_d;
  logic [4:0]  filhit_q;
  logic [4:0]  filhit_d;
  logic [3:0]  rxb_q;
  logic [3:0]  rxb_d;
  logic [3:0]  txb_q;
  logic [3:0]  txb_d;
  logic [6:0]  code_q;
  logic [6:0]  code_d;
  logic        irq_q;
  logic        irq_d;
  logic        ack_q;
  logic        ack_d;
  logic        berr_q;
  logic        berr_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  logic [4:0]  wptr;
  logic [4:0]  rptr;
  logic [6:0]  code_c;
  logic [7:0]  set;
  logic        req;
  logic        wr;
  logic        hit;
  logic [15:0] rd_word;
  logic [15:0] wval;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  can_fifo_ptr #(.IW(5)) u_ptr
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (fsa_q),
    .dmabs_i (dmabs_q),
    .wr_i    (fifo_write_i),
    .rd_i    (fifo_read_i),
    .wptr_o  (wptr),
    .rptr_o  (rptr)
  );

  can_irq_prio u_prio
  (
    .flags_i  (flag_q),
    .rx_buf_i (rxb_q),
    .tx_buf_i (txb_q),
    .code_o   (code_c)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Single-cycle answer; ack drops after one cycle so a held stb is not re-taken
  assign req  = cyc_i && stb_i && !ack_q && !berr_q;
  assign wr   = req && we_i;
  assign hit  = (adr_i[5:4] == can_irq_pkg::PAGE_A) ||
                (adr_i[5:4] == can_irq_pkg::PAGE_B && adr_i[3] == 1'b0);
  assign wval = {sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};

  always_comb
  begin
    rd_word = 16'h0000;                                        // RULE_17
    if (adr_i[5:4] == can_irq_pkg::PAGE_A)
    begin
      unique case (adr_i[3:0])
        can_irq_pkg::OFS_DFILT: rd_word = {11'h000, dfilt_q};  // RULE_01
        can_irq_pkg::OFS_ICODE: rd_word = {3'h0, filhit_q, 1'b0, code_q};
        can_irq_pkg::OFS_FCTRL: rd_word = {dmabs_q, 8'h00, fsa_q};
        can_irq_pkg::OFS_FPTR:  rd_word = {3'h0, wptr, 3'h0, rptr};
        default:                rd_word = 16'h0000;
      endcase
    end
    else if (adr_i[5:4] == can_irq_pkg::PAGE_B)
    begin
      unique case (adr_i[3:0])
        can_irq_pkg::OFS_IFLAG: rd_word = {2'h0, err_state_q, flag_q};
        can_irq_pkg::OFS_IEN:   rd_word = {8'h00, ien_q};
        default:                rd_word = 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register next state
  // ---------------------------------------------------------------
  always_comb
  begin
    set      = 8'h00;
    ack_d    = req && hit;
    berr_d   = req && !hit;
    rdat_d   = (req && !we_i) ? {16'h0000, rd_word} : 32'h0000_0000;
    ien_d    = ien_q;
    dmabs_d  = dmabs_q;
    fsa_d    = fsa_q;
    flag_d   = flag_q;
    // Codes past the last valid filter count load zero into the register
    dfilt_d  = (data_filter_bit_count_i > can_irq_pkg::DFILT_MAX) ? 5'h00 : data_filter_bit_count_i; // RULE_01
    filhit_d = {1'b0, matched_filter_number_i};                // RULE_02
    rxb_d    = rx_done_i ? rx_buf_i : rxb_q;
    txb_d    = tx_done_i ? tx_buf_i : txb_q;
    err_state_d = {tx_bus_off_i,                               // RULE_09
                   tx_error_passive_i, rx_error_passive_i,     // RULE_10
                   tx_error_warning_i, rx_error_warning_i,     // RULE_11
                   tx_error_warning_i | rx_error_warning_i};   // RULE_12
    set[can_irq_pkg::POS_ERR]  = |err_state_d && (err_state_d != err_state_q); // RULE_13
    set[can_irq_pkg::POS_IVR]  = invalid_msg_i;                // RULE_14
    // Wake-up sensing ignores any disable state on purpose
    set[can_irq_pkg::POS_WAK]  = bus_activity_i;               // RULE_18
    set[can_irq_pkg::POS_FIFO] = fifo_almost_full_i;           // RULE_15
    set[can_irq_pkg::POS_OVF]  = rx_overflow_i;
    set[can_irq_pkg::POS_RXB]  = rx_done_i;
    set[can_irq_pkg::POS_TXB]  = tx_done_i;
    if (wr && adr_i[5:4] == can_irq_pkg::PAGE_A && adr_i[3:0] == can_irq_pkg::OFS_FCTRL)
    begin
      if (sel_i[1] && dat_i[15:13] != can_irq_pkg::DMABS_RSVD)
        dmabs_d = dat_i[15:13];                                // RULE_05
      if (sel_i[0])
        fsa_d = dat_i[4:0];                                    // RULE_06
    end
    if (wr && adr_i[5:4] == can_irq_pkg::PAGE_B && adr_i[3:0] == can_irq_pkg::OFS_IEN && sel_i[0])
      ien_d = dat_i[7:0] & can_irq_pkg::FLAG_MASK;             // RULE_16
    // Writing zero clears a flag; ones leave it
    if (wr && adr_i[5:4] == can_irq_pkg::PAGE_B && adr_i[3:0] == can_irq_pkg::OFS_IFLAG && sel_i[0])
      flag_d = flag_q & wval[7:0];                             // RULE_15
    flag_d = (flag_d | set) & can_irq_pkg::FLAG_MASK;          // RULE_17
    irq_d  = |(flag_d & ien_d);                                // RULE_19
    code_d = code_c;                                           // RULE_20
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_q      <= 8'h00;
      ien_q       <= can_irq_pkg::IEN_RST;
      dmabs_q     <= can_irq_pkg::DMABS_RST;
      fsa_q       <= can_irq_pkg::FSA_RST;
      err_state_q <= 6'h00;
      dfilt_q     <= 5'h00;
      filhit_q    <= 5'h00;
      rxb_q       <= 4'h0;
      txb_q       <= 4'h0;
      code_q      <= can_irq_pkg::IC_NONE;
      irq_q       <= 1'b0;
      ack_q       <= 1'b0;
      berr_q      <= 1'b0;
      rdat_q      <= 32'h0000_0000;
    end
    else
    begin
      flag_q      <= flag_d;
      ien_q       <= ien_d;
      dmabs_q     <= dmabs_d;
      fsa_q       <= fsa_d;
      err_state_q <= err_state_d;
      dfilt_q     <= dfilt_d;
      filhit_q    <= filhit_d;
      rxb_q       <= rxb_d;
      txb_q       <= txb_d;
      code_q      <= code_d;
      irq_q       <= irq_d;
      ack_q       <= ack_d;
      berr_q      <= berr_d;
      rdat_q      <= rdat_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dat_o                    = rdat_q;
  assign ack_o                    = ack_q;
  assign err_o                    = berr_q;
  assign irq_o                    = irq_q;
  assign dma_buffer_count_sel_o   = dmabs_q;
  assign fifo_start_index_o       = fsa_q;
  assign fifo_write_pointer_o     = {1'b0, wptr};
  assign fifo_next_read_pointer_o = {1'b0, rptr};
  assign interrupt_source_code_o  = code_q;
endmodule
`default_nettype wire

// >>> can_irq_fifo_status_tb.sv
// Self-checking bench for the CAN status and interrupt block.
// Assumes the engine model drives error levels and events.
`timescale 1ns/1ps
`default_nettype none
module can_irq_fifo_status_tb;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, fw, fr, irq;
  logic [5:0]  adr_i, ev, pulse, wptr, rptr;
  logic [3:0]  sel_i, mfn, rxb, txb;
  logic [31:0] dat_i, dat_o, r;
  logic [4:0]  dfc, st, fsa;
  logic [2:0]  dms;
  logic [6:0]  code;
  logic [8:0]  tec, rec;
  logic        e;
  int fails, checked, i;
  logic [15:0] tv [6];
  logic [6:0]  cv [6];
  always #4 clk_i = ~clk_i;
  can_engine_model eng (.clk_i(clk_i), .rst_i(rst_i), .tec_i(tec), .rec_i(rec), .ev_i(ev),
    .state_o(st), .pulse_o(pulse));
  can_irq_fifo_status dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .data_filter_bit_count_i(dfc), .matched_filter_number_i(mfn), .tx_bus_off_i(st[4]),
    .tx_error_passive_i(st[3]), .rx_error_passive_i(st[2]), .tx_error_warning_i(st[1]),
    .rx_error_warning_i(st[0]), .invalid_msg_i(pulse[5]), .bus_activity_i(pulse[4]),
    .fifo_almost_full_i(pulse[3]), .rx_overflow_i(pulse[2]), .rx_done_i(pulse[1]), .rx_buf_i(rxb),
    .tx_done_i(pulse[0]), .tx_buf_i(txb), .fifo_write_i(fw), .fifo_read_i(fr),
    .dma_buffer_count_sel_o(dms), .fifo_start_index_o(fsa), .fifo_write_pointer_o(wptr),
    .fifo_next_read_pointer_o(rptr), .interrupt_source_code_o(code), .irq_o(irq));
  // ------------------------------------------------------------
  // Bus cycle, compare and verdict
  // ------------------------------------------------------------
  task stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Samples ack at the edge before that edge's updates land
  task wb(input logic w, input logic [5:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 16'h0, d};
    n = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        fails++;
        stop_test();
      end
      @(posedge clk_i);
    end
    r = dat_o;
    e = err_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task rd(input logic [5:0] a, input logic [15:0] x);
    wb(1'b0, a, 16'h0);
    chk(r, {16'h0, x});
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    tv = '{16'h0, 16'h0f40, 16'h0, 16'h0, 16'h0, 16'h0};
    for (i = 0; i < 6; i++)
      rd(6'(i * 4), tv[i]);
    rd(6'h18, 16'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task t_filter;
    tv = '{16'h0, 16'h1, 16'h11, 16'h12, 16'h1f, 16'h0};
    for (i = 0; i < 5; i++)
    begin
      dfc <= tv[i][4:0];
      rd(6'h00, (tv[i] > 16'h11) ? 16'h0 : tv[i]);
    end
  endtask
  task t_fifo;
    wb(1'b1, 6'h08, 16'he000);
    rd(6'h08, 16'h0);
    wb(1'b1, 6'h08, 16'h1fff);
    rd(6'h08, 16'h001f);
    chk({27'h0, fsa}, 32'h1f);
    wb(1'b1, 6'h08, 16'hc000);
    chk({29'h0, dms}, 32'h6);
    wb(1'b1, 6'h08, 16'h0000);
    // Start index 31 pulled both pointers to 31; past the last buffer they wrap to start
    for (i = 1; i <= 5; i++)
    begin
      fw <= 1'b1;
      wait_n(1);
      fw <= 1'b0;
      wait_n(2);
      chk({26'h0, wptr}, 32'((i - 1) % 4));
    end
    for (i = 0; i < 2; i++)
    begin
      fr <= 1'b1;
      wait_n(1);
      fr <= 1'b0;
      wait_n(2);
      chk({26'h0, rptr}, 32'(i));
    end
    rd(6'h0c, 16'h0001);
  endtask
  task t_errstate;
    tv = '{16'h0520, 16'h1520, 16'h2520, 16'h0b20, 16'h0020, 16'h0};
    for (i = 0; i < 5; i++)
    begin
      tec <= (i == 0) ? 9'd96 : (i == 1) ? 9'd128 : (i == 2) ? 9'd256 : 9'd0;
      rec <= (i == 3) ? 9'd128 : 9'd0;
      wait_n(4);
      rd(6'h10, tv[i]);
    end
    chk({25'h0, code}, 32'h41);
  endtask
  task t_irq;
    tv = '{16'hdf, 16'hbf, 16'hfb, 16'hf7, 16'hfd, 16'hfe};
    cv = '{7'h42, 7'h43, 7'h44, 7'h0b, 7'h05, 7'h40};
    chk({31'h0, irq}, 32'h0);
    ev <= 6'h3f;
    wait_n(1);
    ev <= 6'h00;
    rd(6'h10, 16'h00ef);
    wb(1'b1, 6'h14, 16'hffff);
    rd(6'h14, 16'h00ef);
    chk({31'h0, irq}, 32'h1);
    for (i = 0; i < 6; i++)
    begin
      wb(1'b1, 6'h10, tv[i]);
      wait_n(3);
      chk({25'h0, code}, {25'h0, cv[i]});
    end
    rd(6'h10, 16'h0080);
    wb(1'b1, 6'h14, 16'h0000);
    wait_n(2);
    chk({31'h0, irq}, 32'h0);
  endtask
  initial
  begin
    {clk_i, cyc_i, stb_i, we_i, fw, fr} = 6'h0;
    {adr_i, ev, dat_i, dfc} = '0;
    {sel_i, mfn, rxb, txb} = {4'h3, 4'hf, 4'hb, 4'h5};
    {tec, rec} = '0;
    rst_i = 1'b1;
    fails = 0;
    checked = 0;
    wait_n(2);
    rst_i <= 1'b0;
    t_reset();
    t_filter();
    t_fifo();
    t_errstate();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire

// >>> can_irq_pkg.sv
// Constants shared by the CAN status, interrupt and FIFO register block.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
// Operation
// RULE_01: Five-bit data filter count, codes above 10001 invalid
// RULE_02: Report matched filter number zero to fifteen
// RULE_03: Buffer interrupt codes name buffers 0 to 15; transmit codes use only tx_buf_i[2:0], buffers 0 to 7
// RULE_04: Code 1000000 means nothing pending; fixed special codes
// RULE_05: DMA buffer count select maps to 4..32
// RULE_06: Writable FIFO start index zero to thirty-one
// RULE_07: Read-only FIFO write pointer zero to thirty-one
// RULE_08: Read-only FIFO next-read pointer zero to thirty-one
// RULE_09: Bit 13 shows transmitter bus-off state
// RULE_10: Bits 12 and 11 show error passive
// RULE_11: Bits 10 and 9 show error warning
// RULE_12: Bit 8 is either side warning
// RULE_13: Error flag bit 5 set by states
// RULE_14: Invalid-message bit 7, wake-up bit 6 flags
// RULE_15: Flags 3..0 set by hardware, clear only
// RULE_16: Enable bits match flag positions, reset zero
// RULE_17: Unimplemented bits read zero, writes ignored
// RULE_18: Wake-up flag still sets while module disabled
// RULE_19: Interrupt request when flag and enable both set
// RULE_20: Fixed priority code, back to none when clear
`default_nettype none
package can_irq_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_DFILT  = 4'h0;
  localparam logic [3:0] OFS_ICODE  = 4'h4;
  localparam logic [3:0] OFS_FCTRL  = 4'h8;
  localparam logic [3:0] OFS_FPTR   = 4'hc;
  localparam logic [3:0] OFS_IFLAG  = 4'h0;
  localparam logic [3:0] OFS_IEN    = 4'h4;
  localparam logic [1:0] PAGE_A     = 2'h0;
  localparam logic [1:0] PAGE_B     = 2'h1;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_FILHIT   = 8;
  localparam int POS_DMABS    = 13;
  localparam int POS_WPTR     = 8;
  localparam int POS_BUSOFF   = 13;
  localparam int POS_TXPASS   = 12;
  localparam int POS_RXPASS   = 11;
  localparam int POS_TXWARN   = 10;
  localparam int POS_RXWARN   = 9;
  localparam int POS_ANYWARN  = 8;
  localparam int POS_IVR      = 7;
  localparam int POS_WAK      = 6;
  localparam int POS_ERR      = 5;
  localparam int POS_FIFO     = 3;
  localparam int POS_OVF      = 2;
  localparam int POS_RXB      = 1;
  localparam int POS_TXB      = 0;
  localparam logic [7:0] FLAG_MASK = 8'hef;
  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] DFILT_MAX    = 5'h11;
  localparam logic [6:0] IC_NONE      = 7'h40;
  localparam logic [6:0] IC_ERR       = 7'h41;
  localparam logic [6:0] IC_WAKE      = 7'h42;
  localparam logic [6:0] IC_OVF       = 7'h43;
  localparam logic [6:0] IC_FIFO      = 7'h44;
  localparam logic [2:0] DMABS_RSVD   = 3'h7;
  localparam logic [2:0] DMABS_RST    = 3'h0;
  localparam logic [4:0] FSA_RST      = 5'h00;
  localparam logic [7:0] IEN_RST      = 8'h00;
endpackage
`default_nettype wire

// >>> can_irq_prio.sv
// Fixed-priority encoder producing the interrupt source code.
// Assumes flags and buffer numbers are stable for one clock.
`timescale 1ns/1ps
`default_nettype none
module can_irq_prio
(
  input  wire logic [7:0] flags_i,
  input  wire logic [3:0] rx_buf_i,
  input  wire logic [3:0] tx_buf_i,
  output logic      [6:0] code_o
);
  // Error first, buffers last: buffer events are the most frequent
  always_comb
  begin
    code_o = can_irq_pkg::IC_NONE;                             // RULE_04
    if (flags_i[can_irq_pkg::POS_ERR])
      code_o = can_irq_pkg::IC_ERR;                            // RULE_20
    else if (flags_i[can_irq_pkg::POS_WAK])
      code_o = can_irq_pkg::IC_WAKE;
    else if (flags_i[can_irq_pkg::POS_OVF])
      code_o = can_irq_pkg::IC_OVF;
    else if (flags_i[can_irq_pkg::POS_FIFO])
      code_o = can_irq_pkg::IC_FIFO;
    else if (flags_i[can_irq_pkg::POS_RXB])
      code_o = {3'h0, rx_buf_i};                               // RULE_03
    else if (flags_i[can_irq_pkg::POS_TXB])
      code_o = {4'h0, tx_buf_i[2:0]};                          // RULE_03
  end
endmodule
`default_nettype wire
